// ---- hw/psa_defines.svh ----
/*
 * shared constants of the piconet slot access ends: timing, codes, voice gap limits.
 * assumes inclusion by the package and by both end modules.
 */
`ifndef PSA_DEFINES_SVH
`define PSA_DEFINES_SVH
// ----------------------------------------
// timing
// ----------------------------------------
`define PSA_CLK_NS    5
`define PSA_SLOT_NS   625000
`define PSA_SLOT_CYC  ((`PSA_SLOT_NS) / (`PSA_CLK_NS))
`define PSA_CNT_W     16
// ----------------------------------------
// addresses and channel codes
// ----------------------------------------
`define PSA_AM_BCAST  3'h0
`define PSA_LCH_FLUSH 2'h2
`define PSA_LCH_CONT  2'h1
// ----------------------------------------
// master-to-slave packet kinds
// ----------------------------------------
`define PSA_K_NULL    3'h0
`define PSA_K_POLL    3'h1
`define PSA_K_DATA    3'h2
`define PSA_K_UNPARK  3'h3
`define PSA_K_SCAN    3'h4
// ----------------------------------------
// slave-to-master packet kinds
// ----------------------------------------
`define PSA_S_ACCREQ  2'h1
`define PSA_S_REPLY   2'h2
`define PSA_S_DATA    2'h3
// ----------------------------------------
// scatternet voice gap
// ----------------------------------------
`define PSA_GAP_SLOTS  3'h4
`define PSA_VISIT_LO   3'h1
`define PSA_VISIT_HI   3'h2
`endif

// ---- hw/psa_link_if.sv ----
/*
 * slot-level link between the piconet master end and one slave end.
 * assumes both ends run on the same clk_sys; m_slot marks each master slot.
 */
`timescale 1ns/1ps
interface psa_link_if;
    // master-to-slave slot
    logic        m_slot;
    logic        m_valid;
    logic        m_addr_ok;
    logic [2:0]  m_am;
    logic [2:0]  m_kind;
    logic [1:0]  m_lch;
    logic [7:0]  m_pm;
    logic [47:0] m_uid;
    logic        m_by_uid;
    logic [2:0]  m_new_am;
    logic [7:0]  m_arg;
    logic        m_beacon;
    logic        m_win;
    logic [3:0]  m_win_idx;
    logic        m_win_last;
    // slave-to-master slot
    logic        s_valid;
    logic [1:0]  s_kind;
    logic [2:0]  s_am;
    logic [3:0]  s_ar;
    modport master (
        output m_slot, m_valid, m_addr_ok, m_am, m_kind, m_lch, m_pm, m_uid, m_by_uid,
        output m_new_am, m_arg, m_beacon, m_win, m_win_idx, m_win_last,
        input  s_valid, s_kind, s_am, s_ar
    );
    modport slave (
        input  m_slot, m_valid, m_addr_ok, m_am, m_kind, m_lch, m_pm, m_uid, m_by_uid,
        input  m_new_am, m_arg, m_beacon, m_win, m_win_idx, m_win_last,
        output s_valid, s_kind, s_am, s_ar
    );
endinterface : psa_link_if

// ---- hw/psa_master_end.sv ----
/*
 * piconet master end: slot timing, beacon, access window, broadcast, unpark.
 * assumes one slave end on the link interface and user-side control pulses.
 */
`timescale 1ns/1ps
`include "psa_defines.svh"
module psa_master_end
    import psa_pkg::*;
#(
    parameter int SLOT_CYC = `PSA_SLOT_CYC
) (
    // clock, reset, enable
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic        ce,
    // link
    psa_link_if.master       lnk,
    // programmed figures
    input  wire logic [15:0] beacon_per,
    input  wire logic [3:0]  n_acc,
    input  wire logic [3:0]  m_access,
    input  wire psa_cnt_t    n_poll,
    input  wire psa_cnt_t    new_link_timeout,
    input  wire logic [7:0]  broadcast_repeat_count,
    // requests
    input  wire logic        bc_req,
    input  wire logic        up_req,
    input  wire logic [7:0]  up_pm,
    input  wire logic [47:0] up_uid,
    input  wire logic        up_by_uid,
    input  wire logic [2:0]  up_new_am,
    input  wire logic        scan_req,
    input  wire logic [7:0]  scan_len,
    input  wire logic        role_swap,
    // status
    output logic             up_done,
    output logic             up_retry,
    output logic             acc_seen,
    output logic [3:0]       acc_ar,
    output logic             tx_first
);
    typedef struct packed {
        logic [16:0] cyc;
        logic [15:0] idx;
        logic [7:0]  bc_left;
        logic        bc_first;
        logic        up_pend;
        logic        up_sent;
        logic [7:0]  pm;
        logic [47:0] uid;
        logic        by_uid;
        logic [2:0]  am;
        logic        nl_run;
        psa_cnt_t    nl_cnt;
        logic        scan_pend;
        logic [7:0]  scan_len;
        logic [3:0]  wpos;
        logic [3:0]  wnum;
        logic        m_slot, m_valid, m_addr_ok, m_beacon, m_win, m_win_last, m_by_uid;
        logic [2:0]  m_am, m_kind, m_new_am;
        logic [1:0]  m_lch;
        logic [7:0]  m_pm, m_arg;
        logic [47:0] m_uid;
        logic [3:0]  m_win_idx;
        logic        up_done, up_retry, acc_seen, tx_first;
        logic [3:0]  acc_ar;
    } psa_mst_s;

    psa_mst_s r_r;
    psa_mst_s r_nxt;
    logic [15:0] win_end;
    logic        tick;

    assign win_end = {8'h00, 8'(n_acc) * 8'(m_access)};  // full 8-bit product, no wrap
    assign tick    = (r_r.cyc == 17'(SLOT_CYC - 1));

    // ----------------------------------------
    // slot schedule
    // ----------------------------------------
    always_comb begin
        r_nxt          = r_r;
        r_nxt.m_slot   = 1'b0;
        r_nxt.up_done  = 1'b0;
        r_nxt.up_retry = 1'b0;
        r_nxt.acc_seen = 1'b0;
        r_nxt.cyc      = tick ? 17'h0 : r_r.cyc + 17'h1;
        if (bc_req) begin
            r_nxt.bc_left  = broadcast_repeat_count + 8'h1;
            r_nxt.bc_first = 1'b1;
        end
        if (up_req) begin
            r_nxt.up_pend = 1'b1;
            r_nxt.up_sent = 1'b0;
            r_nxt.pm      = up_pm;
            r_nxt.uid     = up_uid;
            r_nxt.by_uid  = up_by_uid;
            r_nxt.am      = up_new_am;
        end
        if (scan_req) begin
            r_nxt.scan_pend = 1'b1;
            r_nxt.scan_len  = scan_len;
        end
        if (role_swap)
            r_nxt.tx_first = ~r_r.tx_first;
        // slave answers
        if (lnk.s_valid && lnk.s_kind == `PSA_S_ACCREQ) begin
            r_nxt.acc_seen = 1'b1;
            r_nxt.acc_ar   = lnk.s_ar;
        end
        if (lnk.s_valid && lnk.s_kind != `PSA_S_ACCREQ && r_r.up_pend
            && lnk.s_am == r_r.am) begin
            r_nxt.up_pend = 1'b0;
            r_nxt.nl_run  = 1'b0;
            r_nxt.up_done = 1'b1;
        end
        if (tick) begin
            r_nxt.m_slot     = 1'b1;
            r_nxt.m_valid    = 1'b0;
            r_nxt.m_beacon   = 1'b0;
            r_nxt.m_win      = 1'b0;
            r_nxt.m_win_last = 1'b0;
            r_nxt.m_am       = `PSA_AM_BCAST;
            r_nxt.m_kind     = `PSA_K_NULL;
            r_nxt.m_lch      = `PSA_LCH_CONT;
            r_nxt.m_pm       = r_r.pm;
            r_nxt.m_uid      = r_r.uid;
            r_nxt.m_by_uid   = r_r.by_uid;
            r_nxt.m_new_am   = r_r.am;
            r_nxt.m_arg      = r_r.scan_len;
            r_nxt.idx        = (r_r.idx >= beacon_per - 16'h1) ? 16'h0 : r_r.idx + 16'h1;
            // beacon slot: something is always sent
            if (r_r.idx == 16'h0) begin
                r_nxt.m_valid  = 1'b1;
                r_nxt.m_beacon = 1'b1;
                r_nxt.wpos     = 4'h1;
                r_nxt.wnum     = 4'h0;
                if (r_r.up_pend && !r_r.up_sent) begin
                    r_nxt.m_kind  = `PSA_K_UNPARK;
                    r_nxt.up_sent = 1'b1;
                end else if (r_r.scan_pend) begin
                    r_nxt.m_kind    = `PSA_K_SCAN;
                    r_nxt.scan_pend = 1'b0;
                end
            end else if (r_r.idx <= win_end) begin
                // access window slot: broadcast, null when idle
                r_nxt.m_valid    = 1'b1;
                r_nxt.m_win      = 1'b1;
                r_nxt.m_win_idx  = r_r.wpos;
                r_nxt.m_win_last = (r_r.idx == win_end);
                r_nxt.wpos       = (r_r.wpos == n_acc) ? 4'h1 : r_r.wpos + 4'h1;
            end else if (r_r.nl_run) begin
                r_nxt.m_valid = 1'b1;
                r_nxt.m_am    = r_r.am;
                r_nxt.m_kind  = `PSA_K_POLL;
            end
            if (r_nxt.m_valid && r_nxt.m_am == `PSA_AM_BCAST
                && r_nxt.m_kind == `PSA_K_NULL && r_r.bc_left != 8'h0) begin
                r_nxt.m_kind   = `PSA_K_DATA;
                r_nxt.m_lch    = r_r.bc_first ? `PSA_LCH_FLUSH : `PSA_LCH_CONT;
                r_nxt.bc_first = 1'b0;
                r_nxt.bc_left  = r_r.bc_left - 8'h1;
            end
            r_nxt.m_addr_ok = r_nxt.m_valid;
            // new-link timer from the end of the post-window listen
            if (r_r.up_pend && r_r.up_sent && r_r.idx == win_end + n_poll) begin
                r_nxt.nl_run = 1'b1;
                r_nxt.nl_cnt = new_link_timeout;
            end else if (r_r.nl_run) begin
                if (r_r.nl_cnt == '0) begin
                    r_nxt.nl_run   = 1'b0;
                    r_nxt.up_sent  = 1'b0;
                    r_nxt.up_retry = 1'b1;
                end else
                    r_nxt.nl_cnt = r_r.nl_cnt - 1'b1;
            end
        end
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst)
            r_r <= '0;
        else if (ce)
            r_r <= r_nxt;
    end

    // link and status outputs
    assign lnk.m_slot     = r_r.m_slot;
    assign lnk.m_valid    = r_r.m_valid;
    assign lnk.m_addr_ok  = r_r.m_addr_ok;
    assign lnk.m_am       = r_r.m_am;
    assign lnk.m_kind     = r_r.m_kind;
    assign lnk.m_lch      = r_r.m_lch;
    assign lnk.m_pm       = r_r.m_pm;
    assign lnk.m_uid      = r_r.m_uid;
    assign lnk.m_by_uid   = r_r.m_by_uid;
    assign lnk.m_new_am   = r_r.m_new_am;
    assign lnk.m_arg      = r_r.m_arg;
    assign lnk.m_beacon   = r_r.m_beacon;
    assign lnk.m_win      = r_r.m_win;
    assign lnk.m_win_idx  = r_r.m_win_idx;
    assign lnk.m_win_last = r_r.m_win_last;
    assign up_done        = r_r.up_done;
    assign up_retry       = r_r.up_retry;
    assign acc_seen       = r_r.acc_seen;
    assign acc_ar         = r_r.acc_ar;
    assign tx_first       = r_r.tx_first;
endmodule : psa_master_end

// ---- hw/psa_pkg.sv ----
/*
 * types of the piconet slot access ends.
 * assumes psa_defines.svh on the include path.
 */
`include "psa_defines.svh"
package psa_pkg;
    // slave end states, one-hot
    typedef enum logic [5:0] {
        PSA_ST_ACTIVE = 6'h01,
        PSA_ST_PARKED = 6'h02,
        PSA_ST_ACCESS = 6'h04,
        PSA_ST_POST   = 6'h08,
        PSA_ST_WPOLL  = 6'h10,
        PSA_ST_SLEEP  = 6'h20
    } psa_sst_e;
    typedef logic [`PSA_CNT_W-1:0] psa_cnt_t;
endpackage : psa_pkg

// ---- hw/psa_slave_end.sv ----
/*
 * slave end: transmit permission, park access, unpark handshake, scan window,
 * scatternet offsets and roles.
 * assumes the master end drives the link on the same clk_sys.
 */
`timescale 1ns/1ps
`include "psa_defines.svh"
module psa_slave_end
    import psa_pkg::*;
(
    // clock, reset, enable
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic        ce,
    // link
    psa_link_if.slave        lnk,
    // programmed figures
    input  wire psa_cnt_t    n_poll,
    input  wire psa_cnt_t    new_link_timeout,
    // identity and park setup
    input  wire logic [47:0] unit_unique_address,
    input  wire logic        am_load,
    input  wire logic [2:0]  active_member_address,
    input  wire logic        park_go,
    input  wire logic [7:0]  parked_member_address,
    input  wire logic [3:0]  access_request_slot_address,
    input  wire logic        acc_req,
    // active traffic
    input  wire logic        tx_pend,
    input  wire logic        sco_slot,
    input  wire logic        voice_packet_three_slot,
    // scatternet
    input  wire logic [27:0] native_clk,
    input  wire logic        off_wr,
    input  wire logic        off_sel,
    input  wire logic [27:0] off_val,
    input  wire logic        pico_sel,
    input  wire logic        page_go,
    input  wire logic        role_swap,
    // status
    output psa_sst_e         state,
    output logic             is_active,
    output logic             tx_go,
    output logic             unpark_ok,
    output logic             scan_on,
    output logic [27:0]      mclk,
    output logic [1:0]       is_master,
    output logic             role_refused,
    output logic             visit_ok
);
    typedef struct packed {
        psa_sst_e        st;
        logic [2:0]      am;
        logic [7:0]      pm;
        logic [3:0]      ar;
        logic            req_pend;
        logic            unparked;
        psa_cnt_t        cnt;
        logic            s_valid;
        logic [1:0]      s_kind;
        logic            tx_go, unpark_ok, scan_arm, scan_on, refused, visit_ok, is_active;
        logic [7:0]      scan_len;
        logic [7:0]      scan_cnt;
        logic [1:0][27:0] off;
        logic [27:0]     mclk;
        logic [1:0]      is_master;
        logic [2:0]      gap;
    } psa_slv_s;

    psa_slv_s r_r;
    psa_slv_s r_nxt;
    logic     bcast_rx;
    logic     unpark_hit;
    logic     own_hdr;

    // header decode of the current master slot
    assign bcast_rx   = lnk.m_slot && lnk.m_valid && lnk.m_addr_ok
                        && lnk.m_am == `PSA_AM_BCAST;
    assign unpark_hit = bcast_rx && lnk.m_kind == `PSA_K_UNPARK
                        && (lnk.m_by_uid ? lnk.m_uid == unit_unique_address
                                         : lnk.m_pm == r_r.pm);
    assign own_hdr    = lnk.m_slot && lnk.m_valid && lnk.m_addr_ok
                        && lnk.m_am == r_r.am && r_r.am != `PSA_AM_BCAST;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        r_nxt           = r_r;
        r_nxt.s_valid   = 1'b0;
        r_nxt.tx_go     = 1'b0;
        r_nxt.unpark_ok = 1'b0;
        r_nxt.refused   = 1'b0;
        if (acc_req)
            r_nxt.req_pend = 1'b1;
        if (am_load)
            r_nxt.am = active_member_address;
        // park / unpark sequence
        case (r_r.st)
            PSA_ST_ACTIVE: begin
                if (park_go) begin
                    r_nxt.st       = PSA_ST_PARKED;
                    r_nxt.pm       = parked_member_address;
                    r_nxt.ar       = access_request_slot_address;
                    r_nxt.am       = `PSA_AM_BCAST;
                    r_nxt.req_pend = 1'b0;
                    r_nxt.unparked = 1'b0;
                end else if (own_hdr) begin
                    r_nxt.s_valid = 1'b1;
                    r_nxt.s_kind  = tx_pend ? `PSA_S_DATA : `PSA_S_REPLY;
                    r_nxt.tx_go   = tx_pend;
                end else if (lnk.m_slot && sco_slot
                             && !(lnk.m_valid && lnk.m_addr_ok)) begin
                    r_nxt.s_valid = 1'b1;
                    r_nxt.s_kind  = `PSA_S_DATA;
                    r_nxt.tx_go   = 1'b1;
                end
            end
            PSA_ST_PARKED, PSA_ST_SLEEP: begin
                if (unpark_hit) begin
                    r_nxt.st       = PSA_ST_ACCESS;
                    r_nxt.unparked = 1'b1;
                    r_nxt.am       = lnk.m_new_am;
                end else if (r_r.req_pend && (r_r.st == PSA_ST_PARKED || lnk.m_beacon))
                    r_nxt.st = PSA_ST_ACCESS;
            end
            PSA_ST_ACCESS: begin
                if (unpark_hit) begin
                    r_nxt.unparked = 1'b1;
                    r_nxt.am       = lnk.m_new_am;
                end else if (bcast_rx && lnk.m_win && r_r.req_pend && !r_r.unparked
                             && lnk.m_win_idx == r_r.ar) begin
                    r_nxt.s_valid = 1'b1;
                    r_nxt.s_kind  = `PSA_S_ACCREQ;
                end
                if (lnk.m_slot && lnk.m_win_last) begin
                    r_nxt.st  = PSA_ST_POST;
                    r_nxt.cnt = n_poll;
                end
            end
            PSA_ST_POST: begin
                if (unpark_hit) begin
                    r_nxt.unparked = 1'b1;
                    r_nxt.am       = lnk.m_new_am;
                end
                if (lnk.m_slot) begin
                    if (r_r.cnt != '0)
                        r_nxt.cnt = r_r.cnt - 1'b1;
                    else if (r_r.unparked || unpark_hit) begin
                        r_nxt.st  = PSA_ST_WPOLL;
                        r_nxt.cnt = new_link_timeout;
                    end else
                        r_nxt.st = PSA_ST_SLEEP;
                end
            end
            PSA_ST_WPOLL: begin
                if (own_hdr && lnk.m_kind == `PSA_K_POLL) begin
                    r_nxt.st        = PSA_ST_ACTIVE;
                    r_nxt.s_valid   = 1'b1;
                    r_nxt.s_kind    = `PSA_S_REPLY;
                    r_nxt.unpark_ok = 1'b1;
                    r_nxt.unparked  = 1'b0;
                    r_nxt.req_pend  = 1'b0;
                end else if (lnk.m_slot) begin
                    if (r_r.cnt != '0)
                        r_nxt.cnt = r_r.cnt - 1'b1;
                    else begin
                        r_nxt.st       = PSA_ST_PARKED;
                        r_nxt.unparked = 1'b0;
                        r_nxt.req_pend = 1'b0;
                        r_nxt.am       = `PSA_AM_BCAST;
                    end
                end
            end
            default: r_nxt.st = PSA_ST_PARKED;
        endcase
        // broadcast scan window from the beacon instant
        if (bcast_rx && lnk.m_kind == `PSA_K_SCAN) begin
            r_nxt.scan_arm = 1'b1;
            r_nxt.scan_len = lnk.m_arg;
        end
        if (lnk.m_slot) begin
            if (lnk.m_beacon && (r_r.scan_arm || r_nxt.scan_arm)) begin
                r_nxt.scan_arm = 1'b0;
                r_nxt.scan_on  = (r_nxt.scan_len != 8'h0);
                r_nxt.scan_cnt = r_nxt.scan_len - 8'h1;
            end else if (r_r.scan_on) begin
                r_nxt.scan_on  = (r_r.scan_cnt != 8'h0);
                r_nxt.scan_cnt = r_r.scan_cnt - 8'h1;
            end
            // voice gap: slots 1 and 2 of four, slots 3 and 4 are guard time
            r_nxt.gap      = sco_slot ? 3'h0 : (r_r.gap == `PSA_GAP_SLOTS ? r_r.gap
                                                                     : r_r.gap + 3'h1);
            r_nxt.visit_ok = voice_packet_three_slot && r_nxt.gap >= `PSA_VISIT_LO
                             && r_nxt.gap <= `PSA_VISIT_HI;
        end
        // scatternet clock offsets and roles
        if (off_wr)
            r_nxt.off[off_sel] = off_val;
        r_nxt.mclk = native_clk + r_r.off[pico_sel];
        if (page_go || role_swap) begin
            if (!r_r.is_master[pico_sel] && r_r.is_master[~pico_sel])
                r_nxt.refused = 1'b1;
            else begin
                r_nxt.is_master[pico_sel] = page_go ? 1'b1
                                                    : ~r_r.is_master[pico_sel];
                if (r_nxt.is_master[pico_sel])
                    r_nxt.off[pico_sel] = 28'h0;
            end
        end
        // active flag kept in a flop so the output needs no gate after it
        r_nxt.is_active = (r_nxt.st == PSA_ST_ACTIVE) || r_nxt.unparked;
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            r_r    <= '0;
            r_r.st <= PSA_ST_ACTIVE;
        end else if (ce)
            r_r <= r_nxt;
    end

    // link and status outputs
    assign lnk.s_valid  = r_r.s_valid;
    assign lnk.s_kind   = r_r.s_kind;
    assign lnk.s_am     = r_r.am;
    assign lnk.s_ar     = r_r.ar;
    assign state        = r_r.st;
    assign is_active    = r_r.is_active;
    assign tx_go        = r_r.tx_go;
    assign unpark_ok    = r_r.unpark_ok;
    assign scan_on      = r_r.scan_on;
    assign mclk         = r_r.mclk;
    assign is_master    = r_r.is_master;
    assign role_refused = r_r.refused;
    assign visit_ok     = r_r.visit_ok;
endmodule : psa_slave_end

// ---- verif/psa_link_props.sv ----
/* link checker: slot-level relations between the two ends.
   assumes one clk_sys domain and sys_rst active high. */
`timescale 1ns/1ps
module psa_link_props (
    // clock and reset
    input wire logic       clk_sys,
    input wire logic       sys_rst,
    // master slot
    input wire logic       m_slot,
    input wire logic       m_valid,
    input wire logic       m_addr_ok,
    input wire logic [2:0] m_am,
    input wire logic [2:0] m_kind,
    input wire logic       m_beacon,
    input wire logic       m_win,
    input wire logic [3:0] m_win_idx,
    // slave slot
    input wire logic       s_valid,
    input wire logic [1:0] s_kind,
    input wire logic [2:0] s_am,
    input wire logic [3:0] s_ar
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    a_reply_after_slot: assert property (s_valid |-> $past(m_slot))
        else $error("slave packet without slot");
    a_reply_own_addr: assert property (s_valid && s_kind == 2'h2 |->
        $past(m_valid && m_addr_ok && m_am == s_am)) else $error("reply not addressed");
    a_bcast_quiet: assert property (m_slot && m_valid && m_am == 3'h0 |=>
        !s_valid || s_kind == 2'h1) else $error("active reply to broadcast");
    a_req_own_slot: assert property (s_valid && s_kind == 2'h1 |->
        $past(m_win && m_valid && m_am == 3'h0 && m_win_idx == s_ar))
        else $error("access request misplaced");
    a_beacon_sent: assert property (m_slot && m_beacon |-> m_valid)
        else $error("silent beacon");
    a_win_bcast: assert property (m_slot && m_win |-> m_valid && m_am == 3'h0)
        else $error("window slot not broadcast");
    a_unpark_bcast: assert property (m_slot && m_valid && m_kind == 3'h3 |-> m_am == 3'h0)
        else $error("unpark not broadcast");
    a_slot_gap: assert property (m_slot |=> !m_slot [*8])
        else $error("slots too close");
endmodule : psa_link_props

// ---- verif/tb.sv ----
/* bench: master and slave ends on one link; offset, access and unpark runs.
   assumes the slot shortened to 20 cycles. */
`timescale 1ns/1ps
module tb;
    import psa_pkg::*;
    logic        clk_sys = 0, sys_rst = 1, ce = 1, bc_req = 0, up_req = 0, scan_req = 0;
    logic        park_go = 0, acc_req = 0, off_wr = 0, acc_seen, unpark_ok, is_active;
    logic [7:0]  pm = 0, rnd = 8'h46;
    logic [3:0]  ar = 0, acc_ar;
    logic [2:0]  am = 0, exp_q[$];
    logic [27:0] mclk, nclk = 0, ov = 0;
    int          miscompares = 0, checked = 0, cyc = 0;
    int          scan_cyc = 0, vis_cyc = 0, bc_n = 0;
    logic        byuid = 0, am_ld = 0, txp = 0, sco = 0, vp3 = 0, osel = 0, psel = 0;
    logic        pg = 0, rsw = 0, up_done, up_retry, tx_first, tx_go, scan_on, role_refused;
    logic        visit_ok;
    logic [1:0]  is_master;
    logic [7:0]  slen = 8'h03;
    logic [15:0] npoll = 16'h0002, nlto = 16'h0006;
    logic [47:0] uid = 48'h1;
    psa_sst_e    state;
    psa_link_if lnk ();
    psa_master_end #(.SLOT_CYC(20)) i_psa_master_end (.clk_sys, .sys_rst, .ce, .lnk,
        .beacon_per(16'h0010), .n_acc(4'h4), .m_access(4'h2), .n_poll(npoll),
        .new_link_timeout(nlto), .broadcast_repeat_count(8'h01), .bc_req, .up_req,
        .up_pm(pm), .up_uid(uid), .up_by_uid(byuid), .up_new_am(am), .scan_req,
        .scan_len(slen), .role_swap(rsw), .up_done, .up_retry, .acc_seen, .acc_ar,
        .tx_first);
    psa_slave_end i_psa_slave_end (.clk_sys, .sys_rst, .ce, .lnk, .n_poll(npoll),
        .new_link_timeout(nlto), .unit_unique_address(uid), .am_load(am_ld),
        .active_member_address(am), .park_go, .parked_member_address(pm),
        .access_request_slot_address(ar), .acc_req, .tx_pend(txp), .sco_slot(sco),
        .voice_packet_three_slot(vp3), .native_clk(nclk), .off_wr, .off_sel(osel),
        .off_val(ov), .pico_sel(psel), .page_go(pg), .role_swap(rsw), .state, .is_active,
        .tx_go, .unpark_ok, .scan_on, .mclk, .is_master, .role_refused, .visit_ok);
    psa_link_props i_psa_link_props (.clk_sys, .sys_rst, .m_slot(lnk.m_slot),
        .m_valid(lnk.m_valid), .m_addr_ok(lnk.m_addr_ok), .m_am(lnk.m_am),
        .m_kind(lnk.m_kind), .m_beacon(lnk.m_beacon), .m_win(lnk.m_win),
        .m_win_idx(lnk.m_win_idx), .s_valid(lnk.s_valid), .s_kind(lnk.s_kind),
        .s_am(lnk.s_am), .s_ar(lnk.s_ar));
    // clock, random steps, compare and verdict
    always #2.5 clk_sys = ~clk_sys;
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : lfsr
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic summarize();
        $display("miscompares=%0d checked=%0d", miscompares, checked);
        if (miscompares == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : summarize
    // watch the slave: request slot, then address taken on unpark
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (scan_on) scan_cyc <= scan_cyc + 1;
        if (visit_ok) vis_cyc <= vis_cyc + 1;
        if (acc_seen) chk(acc_ar, ar);
        if (unpark_ok) chk({is_active, lnk.s_am}, {1'b1, exp_q.pop_front()});
        if (unpark_ok) chk(state, PSA_ST_ACTIVE);
        if (tx_go) chk(lnk.s_kind, 2'h3);
        if (up_retry) chk(up_retry, 1'b0);
        // broadcast data: flush code on the first packet of a message only
        if (lnk.m_slot && lnk.m_kind == 3'h2) begin
            chk(lnk.m_lch, bc_n == 0 ? 2'h2 : 2'h1);
            bc_n <= bc_n + 1;
        end
        if (cyc == 20000) begin
            miscompares++;
            summarize();
        end
    end
    // offset sum, then parked requests answered by unpark
    initial begin
        repeat (4) @(posedge clk_sys);
        sys_rst <= 0;
        nclk <= 28'h123;
        ov <= 28'h40;
        off_wr <= 1;
        @(posedge clk_sys);
        off_wr <= 0;
        repeat (3) @(posedge clk_sys);
        chk(mclk, 28'h163);
        for (int i = 0; i < 2; i++) begin
            rnd = lfsr(rnd);
            exp_q.push_back(3'h1 + 3'(rnd[2:1]));
            pm <= rnd;
            ar <= 4'h1 + 4'(rnd[1:0]);
            am <= 3'h1 + 3'(rnd[2:1]);
            park_go <= 1;
            bc_req <= i[0];
            byuid <= i[0];
            @(posedge clk_sys);
            park_go <= 0;
            bc_req <= 0;
            acc_req <= 1;
            @(posedge clk_sys);
            acc_req <= 0;
            @(posedge clk_sys iff acc_seen);
            up_req <= 1;
            @(posedge clk_sys);
            up_req <= 0;
            @(posedge clk_sys iff unpark_ok);
            @(posedge clk_sys);
            chk(up_done, 1'b1);
        end
        // voice slot with no header, then the voice gap and the role rules
        txp <= 1;
        sco <= 1;
        vp3 <= 1;
        @(posedge clk_sys iff tx_go);
        sco <= 0;
        pg <= 1;
        @(posedge clk_sys);
        pg <= 0;
        psel <= 1;
        rsw <= 1;
        @(posedge clk_sys);
        rsw <= 0;
        @(posedge clk_sys);
        chk({tx_first, role_refused, is_master}, 4'hd);
        rnd = lfsr(rnd);
        slen <= 8'h1 + 8'(rnd[1:0]);
        scan_req <= 1;
        @(posedge clk_sys);
        scan_req <= 0;
        repeat (500) @(posedge clk_sys);
        chk(scan_cyc, 20 * slen);
        chk(vis_cyc, 40);
        chk(bc_n, 2);
        summarize();
    end
endmodule : tb
